// file: design/rtc_irq_power.sv
/*
 * clock interrupt flags, enables, validity, cmos bytes, divider chain,
 * write lockout and battery-backed wake control of a real-time clock.
 * assumes: asynchronous pins are synchronised here; alarm match strobes
 * come from comparator logic on core_clk_i; rst_n_i is the battery reset.
 */
// Function
// - update enable cleared by host reset, freeze rise
// - data-format bit selects binary, never auto-changed
// - hour-format bit selects 24/12, kept through host reset
// - daylight-saving bit always reads zero
// - flag register bit layout, low nibble zero
// - summary flag from any enabled flag
// - interrupt output low exactly while summary set
// - flags cleared by flag read or reset
// - periodic flag on selected tap edge
// - alarm flag on time match
// - update flag after each update cycle
// - read clears returned ones, defers new events
// - enabling a set flag interrupts at once
// - valid bit set only by its read
// - cmos bytes accessible during updates, writes gated by lockout
// - wake control layout, cleared on battery reset
// - missed alarm two powers on at return
// - trickle reset powers on when enabled
// - 22-stage divider, mode selects run/test/reset
// - first update half second after divider release
// - write lockout after power returns, with exceptions
// - oscillator stops in modes 000, 001
// - periodic interrupt gated by enable, reset clears
// - freeze aborts and blocks update cycles
// - divider mode decode
`timescale 1ns/100ps
`default_nettype none
`include "rtc_params.svh"

module rtc_irq_power
	import rtc_pkg::*;
#(
	parameter int unsigned LOCKOUT_CYCLES = `RTC_LOCKOUT_CYCLES  // write lockout length
) (
	input  wire logic            core_clk_i,          // 125 MHz core clock
	input  wire logic            rst_n_i,             // battery power-on reset
	input  wire rtc_bus_req_type bus_req_i,           // register request
	output logic [7:0]           rdata_o,             // read data, cycle after read
	input  wire logic            tick_32k_i,          // 32.768 kHz time base pin
	input  wire logic            host_reset_i,        // host reset pin, high active
	input  wire logic            main_power_good_i,   // main supply above threshold
	input  wire logic            trickle_present_i,   // trickle supply present
	input  wire logic            trickle_por_i,       // trickle power-on reset level
	input  wire logic            battery_low_i,       // battery below valid level
	input  wire logic            alarm_match_i,       // alarm comparator match pulse
	input  wire logic            alarm_two_match_i,   // alarm two match pulse
	output logic                 rtc_irq_out_n_o,     // interrupt, low active
	output logic                 power_on_out_n_o,    // power-on request, low active
	output logic                 host_input_lockout_o, // host writes locked out
	output logic                 osc_enable_o,        // oscillator running
	output logic                 update_tick_o,       // one update cycle pulse
	output logic                 data_format_binary_o, // binary count format
	output logic                 hour_24_o            // 24-hour format
);

	localparam int unsigned NSYNC = 6;  // synchronised pins
	localparam logic [7:0]  CTRL_A_RST = `RTC_CTRL_A_RESET;  // control a after battery reset
	// supplies read as present at reset: no false lockout or false edge
	localparam logic [NSYNC-1:0] SYNC_RST = 6'h0c;

	// synchroniser slots
	localparam int unsigned S_TICK = 0;
	localparam int unsigned S_HRST = 1;
	localparam int unsigned S_PWR  = 2;
	localparam int unsigned S_TRK  = 3;
	localparam int unsigned S_POR  = 4;
	localparam int unsigned S_BATT = 5;

	// whole state of the block except the cmos bytes
	typedef struct packed {
		logic [NSYNC-1:0]            s1;       // first sync stage
		logic [NSYNC-1:0]            s2;       // second sync stage
		logic [NSYNC-1:0]            p;        // previous synced value
		logic [`RTC_DIV_STAGES-1:0]  div;      // divider chain
		logic [3:0]                  rate;     // periodic_rate_select
		logic [2:0]                  mode;     // divider_mode
		logic                        freeze;   // time-freeze bit
		logic                        periodic_int_enable;      // periodic_int_enable
		logic                        alarm_int_enable;      // alarm_int_enable
		logic                        update_done_int_enable;      // update_done_int_enable
		logic                        dm;       // data_format_binary
		logic                        h24;      // hour format
		logic                        pf;       // periodic_flag
		logic                        af;       // alarm_flag
		logic                        uf;       // update_done_flag
		logic                        valid;    // contents_valid
		logic                        rem_en;   // alarm_two_remember_enable
		logic                        por_en;   // trickle_por_wake_enable
		logic                        missed;   // alarm two passed unpowered
		rtc_lock_type                lock;     // lockout state
		logic [22:0]                 lock_cnt; // lockout cycle count
		logic [7:0]                  rdata;    // read data
		logic                        irq_n;    // interrupt output
		logic                        pwr_n;    // power-on output
		logic                        lockout;  // lockout output
		logic                        osc;      // oscillator enable
		logic                        upd;      // update pulse
	} rtc_state_type;

	rtc_state_type q;  // registered state
	rtc_state_type n;  // next state

	logic [7:0] cmos_mem [`RTC_ADDR_GP_FIRST:`RTC_ADDR_GP_LAST];  // general bytes

	// oscillator runs unless mode is 000 or 001
	function automatic logic rtc_osc_on(input logic [2:0] mode);
		rtc_osc_on = (mode[2:1] != 2'b00);
	endfunction : rtc_osc_on

	// chain held in reset for modes 11x
	function automatic logic rtc_div_held(input logic [2:0] mode);
		rtc_div_held = (mode[2:1] == 2'b11);
	endfunction : rtc_div_held

	// divider stage feeding the periodic flag
	function automatic logic [4:0] rtc_tap(input logic [3:0] rate);
		if (rate < 4'h3) begin
			rtc_tap = 5'(rate) + 5'd5;  // rates 1, 2 alias 8, 9
		end else begin
			rtc_tap = 5'(rate) - 5'd2;
		end
	endfunction : rtc_tap

	// combinational helpers
	logic                       tick_rise;  // time base edge
	logic                       hrst;       // synced host reset
	logic                       wr_ok;      // write allowed
	logic                       rd_flags;   // flag register read
	logic                       rd_valid;   // validity register read
	logic                       pf_ev;      // periodic event
	logic                       uf_ev;      // update event
	logic                       in_gp;      // address in cmos range
	logic [`RTC_DIV_STAGES-1:0] div_nx;     // next divider

	// next-state logic
	always_comb begin
		n         = q;
		n.s1      = {battery_low_i, trickle_por_i, trickle_present_i,
		             main_power_good_i, host_reset_i, tick_32k_i};
		n.s2      = q.s1;
		n.p       = q.s2;
		n.upd     = 1'b0;
		n.rdata   = 8'h00;
		tick_rise = q.s2[S_TICK] & ~q.p[S_TICK];
		hrst      = q.s2[S_HRST];
		wr_ok     = bus_req_i.wr & (q.lock == RTC_LOCK_IDLE);
		rd_flags  = bus_req_i.rd & (bus_req_i.addr == `RTC_ADDR_FLAGS);
		rd_valid  = bus_req_i.rd & (bus_req_i.addr == `RTC_ADDR_VALIDITY);
		in_gp     = (bus_req_i.addr >= `RTC_ADDR_GP_FIRST) &&
		            (bus_req_i.addr <= `RTC_ADDR_GP_LAST);

		// divider chain
		if (rtc_div_held(q.mode)) begin
			div_nx = '0;
		end else if (rtc_osc_on(q.mode) && tick_rise) begin
			div_nx = q.div + 1'b1;
		end else begin
			div_nx = q.div;
		end
		n.div = div_nx;

		// half-second stage rise: first one half second after release
		uf_ev = (q.mode == `RTC_MODE_NORMAL) && !q.freeze &&
		        div_nx[`RTC_HALF_SEC_BIT] && !q.div[`RTC_HALF_SEC_BIT];
		n.upd = uf_ev;
		pf_ev = (q.rate != 4'h0) && div_nx[rtc_tap(q.rate)] && !q.div[rtc_tap(q.rate)];

		// register writes
		if (wr_ok && bus_req_i.addr == `RTC_ADDR_CTRL_A) begin
			n.mode = bus_req_i.wdata[6:4];
			n.rate = bus_req_i.wdata[3:0];
		end
		if (wr_ok && bus_req_i.addr == `RTC_ADDR_CTRL_B) begin
			n.freeze = bus_req_i.wdata[`RTC_B_FREEZE];
			n.periodic_int_enable    = bus_req_i.wdata[`RTC_B_PIE];
			n.alarm_int_enable    = bus_req_i.wdata[`RTC_B_AIE];
			n.update_done_int_enable    = bus_req_i.wdata[`RTC_B_UIE];
			n.dm     = bus_req_i.wdata[`RTC_B_DM];
			n.h24    = bus_req_i.wdata[`RTC_B_H24];
		end
		// enables cleared by host reset, update enable also by freeze rise
		if (hrst || (n.freeze && !q.freeze)) begin
			n.update_done_int_enable = 1'b0;
		end
		if (hrst) begin
			n.periodic_int_enable = 1'b0;
			n.alarm_int_enable = 1'b0;
		end

		// flags: read clears what it returns, a same-cycle event survives
		if (hrst) begin
			n.pf = 1'b0;
			n.af = 1'b0;
			n.uf = 1'b0;
		end else begin
			n.pf = (q.pf & ~rd_flags) | pf_ev;
			n.af = (q.af & ~rd_flags) | alarm_match_i;
			n.uf = (q.uf & ~rd_flags) | uf_ev;
		end

		// validity: set by its read, cleared by low battery, set wins
		if (rd_valid) begin
			n.valid = 1'b1;
		end else if (q.s2[S_BATT]) begin
			n.valid = 1'b0;
		end

		// wake control; a write also drops a pending power-on request
		if (wr_ok && bus_req_i.addr == `RTC_ADDR_WAKE) begin
			n.rem_en = bus_req_i.wdata[`RTC_WAKE_REM];
			n.por_en = bus_req_i.wdata[`RTC_WAKE_POR];
			n.pwr_n  = 1'b1;
		end
		if (alarm_two_match_i && !q.s2[S_TRK]) begin
			n.missed = 1'b1;  // alarm two passed with trickle absent
		end
		if (q.s2[S_TRK] && !q.p[S_TRK] && q.missed) begin
			n.missed = 1'b0;
			if (q.rem_en) begin
				n.pwr_n = 1'b0;
			end
		end
		if (q.s2[S_POR] && !q.p[S_POR] && q.por_en) begin
			n.pwr_n = 1'b0;
		end

		// write lockout after main power returns
		unique case (q.lock)
			RTC_LOCK_IDLE: begin
				if (!q.s2[S_PWR]) begin
					n.lock = RTC_LOCK_DOWN;
				end
			end
			RTC_LOCK_DOWN: begin
				if (q.s2[S_PWR]) begin
					n.lock_cnt = '0;
					// skipped outside normal mode or with contents invalid
					n.lock = (q.mode == `RTC_MODE_NORMAL && q.valid) ?
					         RTC_LOCK_HOLD : RTC_LOCK_IDLE;
				end
			end
			RTC_LOCK_HOLD: begin
				n.lock_cnt = q.lock_cnt + 1'b1;
				if (!q.s2[S_PWR]) begin
					n.lock = RTC_LOCK_DOWN;
				end else if (q.lock_cnt == 23'(LOCKOUT_CYCLES - 1)) begin
					n.lock = RTC_LOCK_IDLE;
				end
			end
		endcase
		n.lockout = (n.lock != RTC_LOCK_IDLE);

		// read data, valid only the cycle after the strobe
		if (bus_req_i.rd) begin
			unique case (1'b1)
				bus_req_i.addr == `RTC_ADDR_CTRL_A:
					n.rdata = {1'b0, q.mode, q.rate};
				bus_req_i.addr == `RTC_ADDR_CTRL_B:
					n.rdata = {q.freeze, q.periodic_int_enable, q.alarm_int_enable, q.update_done_int_enable, 1'b0, q.dm, q.h24, 1'b0};
				bus_req_i.addr == `RTC_ADDR_FLAGS:
					n.rdata = {(q.pf & q.periodic_int_enable) | (q.af & q.alarm_int_enable) | (q.uf & q.update_done_int_enable),
					           q.pf, q.af, q.uf, 4'h0};
				bus_req_i.addr == `RTC_ADDR_VALIDITY:
					n.rdata = {q.valid, 7'h00};
				bus_req_i.addr == `RTC_ADDR_WAKE:
					n.rdata = {5'h00, q.por_en, 1'b0, q.rem_en};
				in_gp:
					n.rdata = cmos_mem[bus_req_i.addr];
				default:
					n.rdata = 8'h00;  // unmapped reads zero
			endcase
		end

		// outputs; an enable written onto a set flag fires at once
		n.irq_n = ~((n.pf & n.periodic_int_enable) | (n.af & n.alarm_int_enable) | (n.uf & n.update_done_int_enable));
		n.osc   = rtc_osc_on(n.mode);
	end

	// state register
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q       <= '0;
			q.s1    <= SYNC_RST;
			q.s2    <= SYNC_RST;
			q.p     <= SYNC_RST;
			q.mode  <= CTRL_A_RST[6:4];
			q.rate  <= CTRL_A_RST[3:0];
			q.irq_n <= 1'b1;
			q.pwr_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// cmos bytes, writable during updates, gated only by lockout
	always_ff @(posedge core_clk_i) begin
		if (wr_ok && in_gp) begin
			cmos_mem[bus_req_i.addr] <= bus_req_i.wdata;
		end
	end

	assign rdata_o              = q.rdata;
	assign rtc_irq_out_n_o      = q.irq_n;
	assign power_on_out_n_o     = q.pwr_n;
	assign host_input_lockout_o = q.lockout;
	assign osc_enable_o         = q.osc;
	assign update_tick_o        = q.upd;
	assign data_format_binary_o = q.dm;
	assign hour_24_o            = q.h24;

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_uie_freeze;
		!q.freeze ##1 q.freeze |-> !q.update_done_int_enable;
	endproperty
	a_uie_freeze: assert property (p_uie_freeze) else $error("update enable kept on freeze");

	property p_irq_level;
		rtc_irq_out_n_o == !((q.pf & q.periodic_int_enable) | (q.af & q.alarm_int_enable) | (q.uf & q.update_done_int_enable));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt output mismatch");

	property p_host_reset_clears;
		hrst |=> !q.pf && !q.af && !q.uf && !q.periodic_int_enable && !q.alarm_int_enable && !q.update_done_int_enable;
	endproperty
	a_host_reset_clears: assert property (p_host_reset_clears) else $error("reset left state");

	property p_flag_layout;
		rd_flags |=> rdata_o[3:0] == 4'h0 && rdata_o[6] == $past(q.pf);
	endproperty
	a_flag_layout: assert property (p_flag_layout) else $error("flag read layout wrong");

	property p_read_clears;
		rd_flags && q.pf && !pf_ev && !hrst |=> !q.pf;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flag not cleared by read");

	property p_event_survives;
		pf_ev && !hrst |=> q.pf;
	endproperty
	a_event_survives: assert property (p_event_survives) else $error("periodic event lost");

	property p_valid_by_read;
		$rose(q.valid) |-> $past(rd_valid);
	endproperty
	a_valid_by_read: assert property (p_valid_by_read) else $error("valid set without read");

	property p_dse_zero;
		bus_req_i.rd && bus_req_i.addr == `RTC_ADDR_CTRL_B |=> rdata_o[0] == 1'b0;
	endproperty
	a_dse_zero: assert property (p_dse_zero) else $error("daylight bit not zero");

	property p_lockout_blocks;
		q.lock != RTC_LOCK_IDLE && bus_req_i.wr
			|-> host_input_lockout_o ##1 $stable(q.mode) && $stable(q.dm) && $stable(q.rem_en);
	endproperty
	a_lockout_blocks: assert property (p_lockout_blocks) else $error("write passed lockout");

	property p_osc_stop;
		q.mode[2:1] == 2'b00 ##1 $stable(q.mode) |-> !osc_enable_o;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran in stop mode");

	c_irq: cover property (!rtc_irq_out_n_o ##1 rd_flags);
	c_update: cover property (update_tick_o);
	c_lockout: cover property (q.lock == RTC_LOCK_HOLD);
	c_wake: cover property (!power_on_out_n_o);

endmodule : rtc_irq_power

`default_nettype wire

// file: include/rtc_params.svh
/*
 * constants of the clock interrupt, validity and wake-control block:
 * register offsets, bit positions, reset values and timing counts.
 * assumes a 125 MHz core clock and a 9-bit register address.
 */
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// register offsets (bit 8 selects the wake-control bank)
`define RTC_ADDR_CTRL_A     9'h00a
`define RTC_ADDR_CTRL_B     9'h00b
`define RTC_ADDR_FLAGS      9'h00c
`define RTC_ADDR_VALIDITY   9'h00d
`define RTC_ADDR_GP_FIRST   9'h00e
`define RTC_ADDR_GP_LAST    9'h0ff
`define RTC_ADDR_WAKE       9'h100

// control b bit positions
`define RTC_B_FREEZE        7
`define RTC_B_PIE           6
`define RTC_B_AIE           5
`define RTC_B_UIE           4
`define RTC_B_DM            2
`define RTC_B_H24           1

// wake control bit positions
`define RTC_WAKE_REM        0
`define RTC_WAKE_POR        2

// reset values
`define RTC_CTRL_A_RESET    8'h00
`define RTC_WAKE_RESET      8'h00

// divider modes
`define RTC_MODE_NORMAL     3'h2

// divider: 22 stages, half-second stage index
`define RTC_DIV_STAGES      22
`define RTC_HALF_SEC_BIT    14

// timing: write lockout after main power returns, least time
`define RTC_CLK_PERIOD_NS   8
`define RTC_LOCKOUT_MIN_MS  62
`define RTC_LOCKOUT_CYCLES  ((`RTC_LOCKOUT_MIN_MS * 1000000 + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)

`endif

// file: include/rtc_pkg.sv
/*
 * types of the clock interrupt block: bus request carrier, lockout states.
 * assumes rtc_params.svh for widths where used.
 */
package rtc_pkg;

	// host register request, one cycle per strobe
	typedef struct packed {
		logic [8:0] addr;   // register address
		logic [7:0] wdata;  // write data
		logic       wr;     // write strobe
		logic       rd;     // read strobe
	} rtc_bus_req_type;

	// write lockout states
	typedef enum logic [1:0] {
		RTC_LOCK_IDLE,
		RTC_LOCK_DOWN,
		RTC_LOCK_HOLD
	} rtc_lock_type;

endpackage : rtc_pkg

// file: tb/rtc_host_model.sv
/*
 * host processor model: register bus master of the clock block.
 * assumes one clock; tasks are called by the bench after reset release.
 */
`timescale 1ns/100ps
`default_nettype none

module rtc_host_model
	import rtc_pkg::*;
(
	input  wire logic       core_clk_i, // core clock
	output var  rtc_bus_req_type bus_req_o, // register request
	input  wire logic [7:0] rdata_i     // read data
);
	// bus idle from time zero
	initial bus_req_o = '0;

	// write: one strobe cycle, released at the sampling edge
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		bus_req_o <= {a, d, 1'b1, 1'b0};
		@(posedge core_clk_i);
		bus_req_o <= '0;
	endtask : wr

	// read: data stand only in the cycle after the strobe
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		bus_req_o <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk_i);
		bus_req_o <= '0;
		#1 d = rdata_i;
	endtask : rd
endmodule : rtc_host_model

`default_nettype wire

// file: tb/tb_top.sv
/*
 * self-checking bench of the clock interrupt, validity, wake and lockout block.
 * assumes the host model for bus cycles and a short lockout parameter.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rtc_params.svh"

module tb_top;
	import rtc_pkg::*;
	logic            clk   = 1'b0; // core clock
	logic            rst_n = 1'b0; // battery reset, low active
	rtc_bus_req_type req;          // request from host model
	logic [7:0]      rdata;        // read data
	logic            tick  = 1'b0; // time base pin
	logic            hrst  = 1'b0; // host reset
	logic            pgood = 1'b1; // main power good
	logic            tpres = 1'b1; // trickle present
	logic            tpor  = 1'b0; // trickle power-on reset
	logic            am    = 1'b0; // alarm match
	logic            am2   = 1'b0; // alarm two match
	logic            batt  = 1'b0; // battery low
	logic            irq_n, pon_n, lock, osc, upd, dm, h24; // observed outputs
	int              bad_count = 0; // mismatches
	int              checks    = 0; // comparisons
	int              upd_cnt   = 0; // update pulses seen
	logic [7:0]      v;             // read value

	// 125 MHz clock
	always #4 clk = ~clk;

	rtc_irq_power #(.LOCKOUT_CYCLES(20)) dut (
		.core_clk_i(clk), .rst_n_i(rst_n), .bus_req_i(req), .rdata_o(rdata),
		.tick_32k_i(tick), .host_reset_i(hrst), .main_power_good_i(pgood),
		.trickle_present_i(tpres), .trickle_por_i(tpor), .battery_low_i(batt),
		.alarm_match_i(am), .alarm_two_match_i(am2), .rtc_irq_out_n_o(irq_n),
		.power_on_out_n_o(pon_n), .host_input_lockout_o(lock), .osc_enable_o(osc),
		.update_tick_o(upd), .data_format_binary_o(dm), .hour_24_o(h24)
	);

	rtc_host_model host (.core_clk_i(clk), .bus_req_o(req), .rdata_i(rdata));

	// count update pulses
	always @(posedge clk) if (upd === 1'b1) upd_cnt++;

	// compare one byte, bits zero-extended
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// wait cycles, then settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// time base ticks, two core cycles each
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
	endtask : ticks

	// host reset pulse, long enough for the synchroniser
	task automatic hreset();
		@(posedge clk);
		hrst <= 1'b1;
		repeat (6) @(posedge clk);
		hrst <= 1'b0;
		cyc(6);
	endtask : hreset

	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// watchdog against a hang
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		finish_test();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		chk("irq_n", 8'h01, {7'h0, irq_n});
		chk("power_on_n", 8'h01, {7'h0, pon_n});
		// format bits, reserved and daylight bits
		host.wr(`RTC_ADDR_CTRL_B, 8'h0f);
		host.rd(`RTC_ADDR_CTRL_B, v);
		chk("ctrl_b", 8'h06, v);
		chk("dm_h24", 8'h03, {6'h0, dm, h24});
		// host reset clears enables, keeps format bits
		host.wr(`RTC_ADDR_CTRL_B, 8'h76);
		hreset();
		host.rd(`RTC_ADDR_CTRL_B, v);
		chk("ctrl_b_hrst", 8'h06, v);
		// freeze rising clears update enable
		host.wr(`RTC_ADDR_CTRL_B, 8'h16);
		host.wr(`RTC_ADDR_CTRL_B, 8'h96);
		host.rd(`RTC_ADDR_CTRL_B, v);
		chk("ctrl_b_frz", 8'h86, v);
		host.wr(`RTC_ADDR_CTRL_B, 8'h06);
		// alarm flag without enable, then late enable
		@(posedge clk);
		am <= 1'b1;
		@(posedge clk);
		am <= 1'b0;
		cyc(2);
		chk("irq_n_masked", 8'h01, {7'h0, irq_n});
		host.wr(`RTC_ADDR_CTRL_B, 8'h26);
		cyc(0);
		chk("irq_n_late_en", 8'h00, {7'h0, irq_n});
		host.wr(`RTC_ADDR_FLAGS, 8'hff);
		cyc(0);
		chk("irq_n_flag_wr", 8'h00, {7'h0, irq_n});
		host.rd(`RTC_ADDR_FLAGS, v);
		chk("flags_alarm", 8'ha0, v);
		chk("irq_n_cleared", 8'h01, {7'h0, irq_n});
		host.rd(`RTC_ADDR_FLAGS, v);
		chk("flags_empty", 8'h00, v);
		// host reset wipes a pending flag
		@(posedge clk);
		am <= 1'b1;
		@(posedge clk);
		am <= 1'b0;
		hreset();
		host.rd(`RTC_ADDR_FLAGS, v);
		chk("flags_hrst", 8'h00, v);
		// validity set by its own read, writes ignored
		host.rd(`RTC_ADDR_VALIDITY, v);
		host.wr(`RTC_ADDR_VALIDITY, 8'h00);
		host.rd(`RTC_ADDR_VALIDITY, v);
		chk("validity", 8'h80, v);
		// low battery clears valid, next read sets it again
		@(posedge clk);
		batt <= 1'b1;
		repeat (4) @(posedge clk);
		batt <= 1'b0;
		cyc(4);
		host.rd(`RTC_ADDR_VALIDITY, v);
		chk("valid_batt", 8'h00, v);
		host.rd(`RTC_ADDR_VALIDITY, v);
		chk("valid_reread", 8'h80, v);
		// cmos bytes at both ends
		host.wr(`RTC_ADDR_GP_FIRST, 8'h5a);
		host.wr(`RTC_ADDR_GP_LAST, 8'ha5);
		host.rd(`RTC_ADDR_GP_FIRST, v);
		chk("cmos_first", 8'h5a, v);
		host.rd(`RTC_ADDR_GP_LAST, v);
		chk("cmos_last", 8'ha5, v);
		// wake control layout and trickle reset wake
		host.wr(`RTC_ADDR_WAKE, 8'hff);
		host.rd(`RTC_ADDR_WAKE, v);
		chk("wake", 8'h05, v);
		@(posedge clk);
		tpor <= 1'b1;
		cyc(6);
		chk("pon_por", 8'h00, {7'h0, pon_n});
		host.wr(`RTC_ADDR_WAKE, 8'h01);
		cyc(1);
		chk("pon_clear", 8'h01, {7'h0, pon_n});
		// alarm two missed while trickle absent
		@(posedge clk);
		tpres <= 1'b0;
		tpor  <= 1'b0;
		repeat (5) @(posedge clk);
		am2 <= 1'b1;
		@(posedge clk);
		am2 <= 1'b0;
		repeat (3) @(posedge clk);
		tpres <= 1'b1;
		cyc(6);
		chk("pon_rem", 8'h00, {7'h0, pon_n});
		host.wr(`RTC_ADDR_WAKE, 8'h00);
		// oscillator stop modes
		host.wr(`RTC_ADDR_CTRL_A, 8'h20);
		cyc(2);
		chk("osc_on", 8'h01, {7'h0, osc});
		host.wr(`RTC_ADDR_CTRL_A, 8'h10);
		cyc(2);
		chk("osc_off", 8'h00, {7'h0, osc});
		// frozen run: no update at the half second
		host.wr(`RTC_ADDR_CTRL_A, 8'h70);
		host.wr(`RTC_ADDR_CTRL_B, 8'h86);
		host.wr(`RTC_ADDR_CTRL_A, 8'h20);
		upd_cnt = 0;
		ticks(16384);
		cyc(4);
		chk("upd_frozen", 8'h00, upd_cnt[7:0]);
		// first update half a second after divider release
		host.wr(`RTC_ADDR_CTRL_A, 8'h70);
		host.wr(`RTC_ADDR_CTRL_B, 8'h16);
		host.wr(`RTC_ADDR_CTRL_A, 8'h20);
		upd_cnt = 0;
		ticks(16383);
		cyc(4);
		chk("upd_early", 8'h00, upd_cnt[7:0]);
		ticks(1);
		cyc(4);
		chk("upd_first", 8'h01, upd_cnt[7:0]);
		chk("irq_n_upd", 8'h00, {7'h0, irq_n});
		host.rd(`RTC_ADDR_FLAGS, v);
		chk("flags_upd", 8'h90, v);
		// periodic flag without enable, then enable
		host.wr(`RTC_ADDR_CTRL_B, 8'h06);
		host.wr(`RTC_ADDR_CTRL_A, 8'h23);
		ticks(8);
		cyc(4);
		chk("irq_n_pf_off", 8'h01, {7'h0, irq_n});
		host.wr(`RTC_ADDR_CTRL_B, 8'h46);
		cyc(0);
		chk("irq_n_pf_on", 8'h00, {7'h0, irq_n});
		host.wr(`RTC_ADDR_CTRL_A, 8'h20);
		host.rd(`RTC_ADDR_FLAGS, v);
		chk("flags_pf", 8'hc0, v);
		host.wr(`RTC_ADDR_CTRL_B, 8'h06);
		// lockout after power return in normal mode with valid contents
		@(posedge clk);
		pgood <= 1'b0;
		cyc(5);
		chk("lock_down", 8'h01, {7'h0, lock});
		host.wr(`RTC_ADDR_GP_FIRST, 8'h11);
		host.wr(`RTC_ADDR_CTRL_B, 8'h40);
		@(posedge clk);
		pgood <= 1'b1;
		cyc(12);
		chk("lock_hold", 8'h01, {7'h0, lock});
		for (int i = 0; i < 40 && lock !== 1'b0; i++) @(posedge clk);
		cyc(0);
		chk("lock_end", 8'h00, {7'h0, lock});
		host.rd(`RTC_ADDR_GP_FIRST, v);
		chk("cmos_locked", 8'h5a, v);
		host.rd(`RTC_ADDR_CTRL_B, v);
		chk("ctrl_b_locked", 8'h06, v);
		// no lockout hold outside normal mode
		host.wr(`RTC_ADDR_CTRL_A, 8'h70);
		@(posedge clk);
		pgood <= 1'b0;
		repeat (5) @(posedge clk);
		pgood <= 1'b1;
		cyc(6);
		chk("lock_skip", 8'h00, {7'h0, lock});
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
